// ### rtl/adc_filter_offset_config.sv
// Filter, pin function and offset configuration registers with start delay
//
// What this block does
// - Start delay code 0 none, else 4..1024 modulator periods of two clocks.
// - Delay is timed from start pin rising or start bit write.
// - Order bit 0 runs third FIR before IIR; 1 runs IIR first.
// - Filter bit 2 set bypasses the second FIR section.
// - Filter bit 1 set bypasses the third FIR section.
// - Filter bit 0 bypasses IIR section and resets to one.
// - Pin mode 00 carries serial data only; code 11 is refused.
// - Pin mode 01, the reset value, gives data plus data-ready.
// - Pin mode 10 as dual mode, plus data-ready while select high.
// - Offset word built from three bytes, lowest address most significant.
// - Offset word is two's complement, subtracted from each result.
// - Offset subtraction happens before gain scaling.
// - Oversampling ratio halves per bypassed FIR section, quarter for both.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module adc_filter_offset_config (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_wdata,
   output logic [31:0] wb_rdata,
   output logic wb_ack,
   // Start pin
   input wire logic start_pin,
   // Conversion data path
   input wire logic [23:0] conv_data,
   input wire logic conv_valid,
   output logic [23:0] pre_gain_data,
   output logic pre_gain_valid,
   // Filter control
   output logic section_order_select,
   output logic second_fir_bypass,
   output logic third_fir_bypass,
   output logic recursive_section_bypass,
   output logic [1:0] osr_shift,
   output logic conversion_start,
   // Shared serial output pin
   input wire logic cs_n,
   input wire logic sdo_bit,
   input wire logic shift_active,
   input wire logic drdy_n,
   output logic shared_out_ready_pin,
   output logic shared_out_ready_oe
);
   import adc_cfg_pkg::*;

   // ==========================================
   // Declarations
   logic [5:0] idx;
   logic bus_req;
   logic wr_take;
   logic next_ack;
   logic [31:0] next_rdata;
   logic [7:0] filter_section_control;
   logic [7:0] filter_pin_function;
   logic [7:0] off_high;
   logic [7:0] off_mid;
   logic [7:0] off_low;
   logic [7:0] next_filter_section_control;
   logic [7:0] next_filter_pin_function;
   logic [7:0] next_off_high;
   logic [7:0] next_off_mid;
   logic [7:0] next_off_low;
   logic start_prev;
   logic next_start_prev;
   logic start_wr;
   logic [1:0] next_osr_shift;
   logic next_pin;
   logic next_oe;
   pin_mode_t pin_mode;
   logic [23:0] offset_word;

   start_delay_if dly_bus ();

   // ==========================================
   // Bus decode
   assign idx = wb_adr[7:2];
   assign bus_req = wb_cyc && wb_stb;
   assign wr_take = bus_req && wb_we && wb_ack && wb_sel[0];

   always_comb begin
      next_ack = bus_req && !wb_ack;
      next_rdata = 32'h00000000;
      if (bus_req && !wb_ack && !wb_we) begin
         if (idx == IDX_FILTER_SECTION_CONTROL) begin
            next_rdata = {24'h000000, filter_section_control & FILTER_SECTION_CONTROL_MASK};
         end else if (idx == IDX_FILTER_PIN_FUNCTION) begin
            next_rdata = {24'h000000, filter_pin_function & FILTER_PIN_FUNCTION_MASK};
         end else if (idx == IDX_OFF_HIGH) begin
            next_rdata = {24'h000000, off_high};
         end else if (idx == IDX_OFF_MID) begin
            next_rdata = {24'h000000, off_mid};
         end else if (idx == IDX_OFF_LOW) begin
            next_rdata = {24'h000000, off_low};
         end else if (idx == IDX_CONTROL) begin
            next_rdata = {30'h0, dly_bus.busy, 1'b0};
         end else begin
            next_rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack <= 1'b0;
         wb_rdata <= 32'h00000000;
      end else begin
         wb_ack <= next_ack;
         wb_rdata <= next_rdata;
      end
   end

   // ==========================================
   // Configuration registers
   always_comb begin
      next_filter_section_control = filter_section_control;
      next_filter_pin_function = filter_pin_function;
      next_off_high = off_high;
      next_off_mid = off_mid;
      next_off_low = off_low;
      if (wr_take) begin
         if (idx == IDX_FILTER_SECTION_CONTROL) begin
            next_filter_section_control = wb_wdata[7:0] & FILTER_SECTION_CONTROL_MASK;
         end else if (idx == IDX_FILTER_PIN_FUNCTION) begin
            if (wb_wdata[1:0] != PIN_RESERVED) begin
               next_filter_pin_function = wb_wdata[7:0] & FILTER_PIN_FUNCTION_MASK;
            end
         end else if (idx == IDX_OFF_HIGH) begin
            next_off_high = wb_wdata[7:0];
         end else if (idx == IDX_OFF_MID) begin
            next_off_mid = wb_wdata[7:0];
         end else if (idx == IDX_OFF_LOW) begin
            next_off_low = wb_wdata[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         filter_section_control <= FILTER_SECTION_CONTROL_RST;
         filter_pin_function <= FILTER_PIN_FUNCTION_RST;
         off_high <= OFFSET_RST;
         off_mid <= OFFSET_RST;
         off_low <= OFFSET_RST;
      end else begin
         filter_section_control <= next_filter_section_control;
         filter_pin_function <= next_filter_pin_function;
         off_high <= next_off_high;
         off_mid <= next_off_mid;
         off_low <= next_off_low;
      end
   end

   assign section_order_select = filter_section_control[ORDER_BIT];
   assign second_fir_bypass = filter_section_control[FIR2_BIT];
   assign third_fir_bypass = filter_section_control[FIR3_BIT];
   assign recursive_section_bypass = filter_section_control[IIR_BIT];
   assign pin_mode = pin_mode_t'(filter_pin_function[1:0]);
   assign offset_word = {off_high, off_mid, off_low};

   // ==========================================
   // Start trigger and oversampling divisor
   assign start_wr = wr_take && idx == IDX_CONTROL && wb_wdata[START_BIT];

   always_comb begin
      next_start_prev = start_pin;
      case ({second_fir_bypass, third_fir_bypass})
         2'b11: next_osr_shift = OSR_DIV4;
         2'b10: next_osr_shift = OSR_DIV2;
         2'b01: next_osr_shift = OSR_DIV2;
         default: next_osr_shift = OSR_DIV1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_prev <= 1'b0;
         osr_shift <= OSR_DIV1;
      end else begin
         start_prev <= next_start_prev;
         osr_shift <= next_osr_shift;
      end
   end

   assign dly_bus.trigger = (start_pin && !start_prev) || start_wr;
   assign dly_bus.delay_code = filter_section_control[DELAY_LSB +: 3];
   assign conversion_start = dly_bus.conv_start;

   start_delay_timer u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .dly(dly_bus.timer)
   );

   // ==========================================
   // Offset path
   offset_subtract u_offset (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .conv_data(conv_data),
      .conv_valid(conv_valid),
      .offset_word(offset_word),
      .pre_gain_data(pre_gain_data),
      .pre_gain_valid(pre_gain_valid)
   );

   // ==========================================
   // Shared output pin
   always_comb begin
      next_pin = 1'b1;
      next_oe = 1'b0;
      case (pin_mode)
         PIN_DATA_ONLY: begin
            next_oe = !cs_n;
            next_pin = sdo_bit;
         end
         PIN_DUAL: begin
            next_oe = !cs_n;
            next_pin = shift_active ? sdo_bit : drdy_n;
         end
         PIN_DUAL_CS_HIGH: begin
            next_oe = 1'b1;
            if (cs_n) begin
               next_pin = drdy_n;
            end else begin
               next_pin = shift_active ? sdo_bit : drdy_n;
            end
         end
         default: begin
            next_oe = 1'b0;
            next_pin = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shared_out_ready_pin <= 1'b1;
         shared_out_ready_oe <= 1'b0;
      end else begin
         shared_out_ready_pin <= next_pin;
         shared_out_ready_oe <= next_oe;
      end
   end

   // ==========================================
   // Checks
   default clocking chk_clk @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   ack_pulse_a: assert property (
      wb_ack |=> !wb_ack)
      else $error("ack held too long");

   ack_latency_a: assert property (
      bus_req && !wb_ack |=> wb_ack)
      else $error("ack not one cycle after request");

   order_write_a: assert property (
      wr_take && idx == IDX_FILTER_SECTION_CONTROL
      |=> section_order_select == $past(wb_wdata[ORDER_BIT]))
      else $error("order bit not taken");

   fir2_write_a: assert property (
      wr_take && idx == IDX_FILTER_SECTION_CONTROL
      |=> second_fir_bypass == $past(wb_wdata[FIR2_BIT]))
      else $error("second section bypass not taken");

   fir3_write_a: assert property (
      wr_take && idx == IDX_FILTER_SECTION_CONTROL
      |=> third_fir_bypass == $past(wb_wdata[FIR3_BIT]))
      else $error("third section bypass not taken");

   iir_reset_a: assert property (
      $rose(rst_n) |-> recursive_section_bypass && pin_mode == PIN_DUAL)
      else $error("reset values wrong");

   osr_quarter_a: assert property (
      (second_fir_bypass && third_fir_bypass) [*2] |-> osr_shift == OSR_DIV4)
      else $error("ratio not quartered");

   osr_half_a: assert property (
      (second_fir_bypass ^ third_fir_bypass) [*2] |-> osr_shift == OSR_DIV2)
      else $error("ratio not halved");

   mode_refused_a: assert property (
      wr_take && idx == IDX_FILTER_PIN_FUNCTION && wb_wdata[1:0] == PIN_RESERVED |=> $stable(filter_pin_function))
      else $error("reserved pin mode accepted");

   data_only_a: assert property (
      pin_mode == PIN_DATA_ONLY && cs_n |=> !shared_out_ready_oe)
      else $error("pin driven while deselected");

   dual_ready_a: assert property (
      pin_mode == PIN_DUAL && !cs_n && !shift_active
      |=> shared_out_ready_oe && shared_out_ready_pin == $past(drdy_n))
      else $error("ready not shown in dual mode");

   cs_high_ready_a: assert property (
      pin_mode == PIN_DUAL_CS_HIGH && cs_n
      |=> shared_out_ready_oe && shared_out_ready_pin == $past(drdy_n))
      else $error("ready not shown with select high");

   offset_high_a: assert property (
      wr_take && idx == IDX_OFF_HIGH |=> offset_word[23:16] == $past(wb_wdata[7:0]))
      else $error("offset high byte misplaced");

   reserved_zero_a: assert property (
      wb_ack && !wb_we && idx == IDX_FILTER_PIN_FUNCTION |-> wb_rdata[31:2] == 30'h00000000)
      else $error("reserved bits read nonzero");

   start_write_a: assert property (
      start_wr |=> dly_bus.busy || conversion_start)
      else $error("start bit did not arm delay");

endmodule : adc_filter_offset_config
`default_nettype wire

// ### rtl/offset_subtract.sv
// Offset subtraction ahead of the gain stage, saturating to 24 bits
`timescale 1ns/1ps
`default_nettype none
module offset_subtract (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Conversion input and offset
   input wire logic [23:0] conv_data,
   input wire logic conv_valid,
   input wire logic [23:0] offset_word,
   // Toward gain stage
   output logic [23:0] pre_gain_data,
   output logic pre_gain_valid
);
   logic [24:0] diff;
   logic [23:0] next_data;

   // ==========================================
   // Subtract and clamp
   always_comb begin
      diff = {conv_data[23], conv_data} - {offset_word[23], offset_word};
      next_data = pre_gain_data;
      if (conv_valid) begin
         if (diff[24] != diff[23]) begin
            next_data = diff[24] ? 24'h800000 : 24'h7FFFFF;
         end else begin
            next_data = diff[23:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_gain_data <= 24'h000000;
         pre_gain_valid <= 1'b0;
      end else begin
         pre_gain_data <= next_data;
         pre_gain_valid <= conv_valid;
      end
   end

   sub_exact_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_valid && conv_data == offset_word |=> pre_gain_data == 24'h000000 && pre_gain_valid)
      else $error("offset not subtracted");
   sub_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      conv_valid && conv_data == 24'h7FFFFF && offset_word == 24'hFFFFFF
      |=> pre_gain_data == 24'h7FFFFF)
      else $error("positive clamp missing");
   pre_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pre_gain_valid |-> $past(conv_valid))
      else $error("gain stage fed without input");
endmodule : offset_subtract
`default_nettype wire

// ### rtl/start_delay_timer.sv
// Start delay timer counting modulator periods before the first conversion
`timescale 1ns/1ps
`default_nettype none
module start_delay_timer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control link
   start_delay_if.timer dly
);
   import adc_cfg_pkg::*;
   timer_state_t state;
   timer_state_t next_state;
   delay_count_t cnt;
   delay_count_t next_cnt;
   logic next_start;

   // ==========================================
   // Countdown
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_start = 1'b0;
      if (dly.trigger) begin
         if (dly.delay_code == 3'h0) begin
            next_start = 1'b1;
            next_state = T_IDLE;
         end else begin
            next_cnt = delay_cycles(dly.delay_code) - 12'h001;
            next_state = T_WAIT;
         end
      end else begin
         case (state)
            T_WAIT: begin
               if (cnt == 12'h001) begin
                  next_start = 1'b1;
                  next_state = T_IDLE;
               end else begin
                  next_cnt = cnt - 12'h001;
               end
            end
            default: begin
               next_state = T_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= T_IDLE;
         cnt <= 12'h000;
         dly.conv_start <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         dly.conv_start <= next_start;
      end
   end

   assign dly.busy = (state == T_WAIT);

   // ==========================================
   // Checks
   zero_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dly.trigger && dly.delay_code == 3'h0 |=> dly.conv_start)
      else $error("zero delay start late");
   four_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dly.trigger && dly.delay_code == 3'h1 ##1 (!dly.trigger) [*7] |=> dly.conv_start)
      else $error("four period delay wrong");
   no_early_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == T_WAIT && cnt != 12'h001 && !dly.trigger |=> !dly.conv_start)
      else $error("start came early");
endmodule : start_delay_timer
`default_nettype wire

// ### shared/adc_cfg_pkg.sv
// Constants, types and delay table for the filter and offset configuration block
`default_nettype none
package adc_cfg_pkg;
   // Word indices; byte address is four times the index
   localparam logic [5:0] IDX_FILTER_SECTION_CONTROL = 6'h0A;
   localparam logic [5:0] IDX_FILTER_PIN_FUNCTION = 6'h0B;
   localparam logic [5:0] IDX_OFF_HIGH = 6'h0C;
   localparam logic [5:0] IDX_OFF_MID = 6'h0D;
   localparam logic [5:0] IDX_OFF_LOW = 6'h0E;
   localparam logic [5:0] IDX_CONTROL = 6'h20;
   // Reset values and writable masks
   localparam logic [7:0] FILTER_SECTION_CONTROL_RST = 8'h01;
   localparam logic [7:0] FILTER_PIN_FUNCTION_RST = 8'h01;
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [7:0] FILTER_SECTION_CONTROL_MASK = 8'h7F;
   localparam logic [7:0] FILTER_PIN_FUNCTION_MASK = 8'h03;
   // Field positions
   localparam int DELAY_LSB = 4;
   localparam int ORDER_BIT = 3;
   localparam int FIR2_BIT = 2;
   localparam int FIR3_BIT = 1;
   localparam int IIR_BIT = 0;
   localparam int START_BIT = 0;
   localparam int BUSY_BIT = 1;
   // Oversampling divisor as a right shift
   localparam logic [1:0] OSR_DIV1 = 2'h0;
   localparam logic [1:0] OSR_DIV2 = 2'h1;
   localparam logic [1:0] OSR_DIV4 = 2'h2;
   // Start delay in modulator periods; modulator rate is clock / 2
   localparam int CLK_PER_MOD = 2;
   localparam int DLY_MOD_1 = 4;
   localparam int DLY_MOD_2 = 8;
   localparam int DLY_MOD_3 = 16;
   localparam int DLY_MOD_4 = 32;
   localparam int DLY_MOD_5 = 128;
   localparam int DLY_MOD_6 = 512;
   localparam int DLY_MOD_7 = 1024;
   typedef logic [11:0] delay_count_t;
   localparam delay_count_t DLY_CYC_1 = delay_count_t'(DLY_MOD_1 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_2 = delay_count_t'(DLY_MOD_2 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_3 = delay_count_t'(DLY_MOD_3 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_4 = delay_count_t'(DLY_MOD_4 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_5 = delay_count_t'(DLY_MOD_5 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_6 = delay_count_t'(DLY_MOD_6 * CLK_PER_MOD);
   localparam delay_count_t DLY_CYC_7 = delay_count_t'(DLY_MOD_7 * CLK_PER_MOD);
   typedef enum logic [1:0] {
      PIN_DATA_ONLY = 2'b00,
      PIN_DUAL = 2'b01,
      PIN_DUAL_CS_HIGH = 2'b10,
      PIN_RESERVED = 2'b11
   } pin_mode_t;
   typedef enum logic {
      T_IDLE = 1'b0,
      T_WAIT = 1'b1
   } timer_state_t;
   function automatic delay_count_t delay_cycles(input logic [2:0] code);
      case (code)
         3'h1: delay_cycles = DLY_CYC_1;
         3'h2: delay_cycles = DLY_CYC_2;
         3'h3: delay_cycles = DLY_CYC_3;
         3'h4: delay_cycles = DLY_CYC_4;
         3'h5: delay_cycles = DLY_CYC_5;
         3'h6: delay_cycles = DLY_CYC_6;
         3'h7: delay_cycles = DLY_CYC_7;
         default: delay_cycles = 12'h000;
      endcase
   endfunction : delay_cycles
endpackage : adc_cfg_pkg
`default_nettype wire

// ### shared/start_delay_if.sv
// Link between register logic and the start delay timer
`timescale 1ns/1ps
`default_nettype none
interface start_delay_if;
   logic trigger;
   logic [2:0] delay_code;
   logic busy;
   logic conv_start;
   modport ctrl (output trigger, output delay_code, input busy, input conv_start);
   modport timer (input trigger, input delay_code, output busy, output conv_start);
endinterface : start_delay_if
`default_nettype wire

// ### testbench/adc_filter_offset_config_tb_top.sv
// Self-checking bench for the filter, pin function and offset registers
`timescale 1ns/1ps
`default_nettype none
module adc_filter_offset_config_tb_top;
   import adc_cfg_pkg::*;
   typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] rd;} row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdata = 32'h00000000;
   logic [31:0] wb_rdata;
   logic wb_ack;
   logic start_pin = 1'b0;
   logic [23:0] conv_data = 24'h000000;
   logic conv_valid = 1'b0;
   logic [23:0] pre_gain_data;
   logic pre_gain_valid, section_order_select, second_fir_bypass, third_fir_bypass;
   logic recursive_section_bypass, conversion_start, shared_out_ready_pin, shared_out_ready_oe;
   logic [1:0] osr_shift;
   logic cs_n, sdo_bit, shift_active, drdy_n;
   logic frame_go = 1'b0;
   logic pin_chk = 1'b0;
   logic [1:0] pin_mode = 2'h1;
   logic [31:0] rd;
   int failures = 0;
   int cmp_count = 0;
   int per_tab [8] = '{0, 4, 8, 16, 32, 128, 512, 1024};
   row_t rows [14] = '{'{8'h28, 8'hFF, 8'h7F}, '{8'h28, 8'h08, 8'h08}, '{8'h28, 8'h04, 8'h04},
      '{8'h28, 8'h02, 8'h02}, '{8'h28, 8'h06, 8'h06}, '{8'h28, 8'h01, 8'h01},
      '{8'h2C, 8'hFC, 8'h00}, '{8'h2C, 8'h03, 8'h00}, '{8'h2C, 8'h02, 8'h02},
      '{8'h2C, 8'h01, 8'h01}, '{8'h30, 8'hAB, 8'hAB}, '{8'h34, 8'hCD, 8'hCD},
      '{8'h38, 8'hEF, 8'hEF}, '{8'h3C, 8'h55, 8'h00}};
   logic [71:0] conv_tab [5] = '{{24'h000010, 24'h000100, 24'h0000F0},
      {24'hFFFFF0, 24'h000100, 24'h000110}, {24'hFFFFFF, 24'h7FFFFF, 24'h7FFFFF},
      {24'h000010, 24'h800000, 24'h800000}, {24'h123456, 24'h123456, 24'h000000}};

   always #2.5 sys_clk = ~sys_clk;

   adc_filter_offset_config dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
      .wb_rdata(wb_rdata), .wb_ack(wb_ack), .start_pin(start_pin), .conv_data(conv_data),
      .conv_valid(conv_valid), .pre_gain_data(pre_gain_data), .pre_gain_valid(pre_gain_valid),
      .section_order_select(section_order_select), .second_fir_bypass(second_fir_bypass),
      .third_fir_bypass(third_fir_bypass), .recursive_section_bypass(recursive_section_bypass),
      .osr_shift(osr_shift), .conversion_start(conversion_start), .cs_n(cs_n),
      .sdo_bit(sdo_bit), .shift_active(shift_active), .drdy_n(drdy_n),
      .shared_out_ready_pin(shared_out_ready_pin), .shared_out_ready_oe(shared_out_ready_oe));

   spi_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .frame_go(frame_go), .cs_n(cs_n),
      .shift_active(shift_active), .sdo_bit(sdo_bit), .drdy_n(drdy_n));

   // ==========================================
   // Tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [7:0] wd,
                          output logic [31:0] data);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_wdata <= {24'h000000, wd};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      data = wb_rdata;
      if (n >= 20) begin
         failures++;
         $display("[FAIL] bus ack expected 1 seen 0");
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge sys_clk);
   endtask : wb_xfer

   task automatic wait_start(input int n);
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         #1;
         k++;
      end while (conversion_start !== 1'b1 && k < 2100);
      chk("start delay", 32'(n), 32'(k));
      @(posedge sys_clk);
   endtask : wait_start

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // ==========================================
   // Pin function watcher
   always @(posedge sys_clk) begin
      logic pc, ps, pd, pr, eo, ep;
      if (pin_chk) begin
         pc = cs_n;
         ps = shift_active;
         pd = sdo_bit;
         pr = drdy_n;
         #1;
         eo = (pin_mode == 2'h2) ? 1'b1 : !pc;
         ep = (pin_mode == 2'h2 && pc) ? pr : ((pin_mode == 2'h0 || ps) ? pd : pr);
         chk("pin and enable", {30'h0, eo, ep},
            {30'h0, shared_out_ready_oe, shared_out_ready_pin});
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         wb_xfer(rows[i].adr, 1'b1, rows[i].wd, rd);
         wb_xfer(rows[i].adr, 1'b0, 8'h00, rd);
         chk("readback", {24'h000000, rows[i].rd}, rd);
         if (rows[i].adr == 8'h28) begin
            chk("filter bits", {28'h0000000, rows[i].rd[3:0]},
               {28'h0000000, section_order_select, second_fir_bypass, third_fir_bypass,
               recursive_section_bypass});
            chk("osr shift", (rows[i].rd[2:1] == 2'h3) ? 32'h2 : 32'(|rows[i].rd[2:1]),
               {30'h0, osr_shift});
         end
      end
      $display("register table done");
      foreach (conv_tab[i]) begin
         wb_xfer(8'h30, 1'b1, conv_tab[i][71:64], rd);
         wb_xfer(8'h34, 1'b1, conv_tab[i][63:56], rd);
         wb_xfer(8'h38, 1'b1, conv_tab[i][55:48], rd);
         conv_data <= conv_tab[i][47:24];
         conv_valid <= 1'b1;
         @(posedge sys_clk);
         conv_valid <= 1'b0;
         #1;
         chk("result valid", 32'h00000001, {31'h0, pre_gain_valid});
         chk("result data", {8'h00, conv_tab[i][23:0]}, {8'h00, pre_gain_data});
         @(posedge sys_clk);
      end
      $display("offset done");
      for (int c = 0; c < 8; c++) begin
         wb_xfer(8'h28, 1'b1, {1'b0, 3'(c), 4'h0}, rd);
         start_pin <= 1'b1;
         wait_start((per_tab[c] == 0) ? 1 : 2 * per_tab[c]);
         start_pin <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
      wb_xfer(8'h28, 1'b1, 8'h30, rd);
      wb_xfer(8'h80, 1'b1, 8'h01, rd);
      wb_xfer(8'h80, 1'b0, 8'h00, rd);
      chk("delay busy", 32'h00000002, rd);
      // Counted from bus return, four edges after the trigger edge
      wait_start(2 * per_tab[3] - 5);
      $display("start delay done");
      for (int m = 0; m < 3; m++) begin
         wb_xfer(8'h2C, 1'b1, 8'(m), rd);
         pin_mode = 2'(m);
         pin_chk = 1'b1;
         frame_go <= 1'b1;
         repeat (40) @(posedge sys_clk);
         pin_chk = 1'b0;
         frame_go <= 1'b0;
      end
      $display("pin function done");
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("idle enable", 32'h0, {31'h0, shared_out_ready_oe});
      chk("iir bypass", 32'h1, {31'h0, recursive_section_bypass});
      rst_n <= 1'b1;
      @(posedge sys_clk);
      wb_xfer(8'h28, 1'b0, 8'h00, rd);
      chk("filter reset", {24'h000000, FILTER_SECTION_CONTROL_RST}, rd);
      wb_xfer(8'h2C, 1'b0, 8'h00, rd);
      chk("pin mode reset", {24'h000000, FILTER_PIN_FUNCTION_RST}, rd);
      wb_xfer(8'h30, 1'b0, 8'h00, rd);
      chk("offset reset", {24'h000000, OFFSET_RST}, rd);
      $display("reset done");
      stop_test();
   end
endmodule : adc_filter_offset_config_tb_top
`default_nettype wire

// ### testbench/spi_host_model.sv
// Host-side model of the serial reader driving select, shift and ready lines
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Frame request from the bench
   input wire logic frame_go,
   // Lines toward the device
   output logic cs_n,
   output logic shift_active,
   output logic sdo_bit,
   output logic drdy_n
);
   logic [4:0] cnt;
   logic [3:0] tick;
   // Single device on the line, so no daisy chain and any pin mode is usable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 5'h00;
         tick <= 4'h0;
         cs_n <= 1'b1;
         shift_active <= 1'b0;
         sdo_bit <= 1'b0;
         drdy_n <= 1'b1;
      end else begin
         tick <= tick + 4'h1;
         // Toggles every cycle so a stale level never passes
         sdo_bit <= ~sdo_bit;
         drdy_n <= (tick[3:2] != 2'h0);
         if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end else if (frame_go) begin
            cnt <= 5'h12;
         end
         cs_n <= (cnt < 5'h02);
         shift_active <= (cnt > 5'h03) && (cnt < 5'h10);
      end
   end
endmodule : spi_host_model
`default_nettype wire
